// file: common/sas_frame_consts.svh
// constants for the address frame builder: layout, codes, crc
// assumes byte-serial framing, byte 0 first, crc bytes msb first
`ifndef SAS_FRAME_CONSTS_SVH
`define SAS_FRAME_CONSTS_SVH

// ==========================================================
// frame layout
`define FRAME_LAST        5'h1F
`define CRC_FIRST_BYTE    5'h1C
`define CRC_LAST_DATA     5'h1B
`define BYTE_NAME         5'h04
`define BYTE_ADDR         5'h0C
`define BYTE_PHY          5'h14
`define BYTE_CAPS         5'h15
`define BYTE_PWRDIS       5'h16
`define BYTE_INIT         5'h02
`define BYTE_TGT          5'h03

// ==========================================================
// field codes
`define TYPE_IDENTIFY     4'h0
`define TYPE_OPEN         4'h1
`define DEV_END           3'h1
`define INIT_PORT_BITS    3'h0
`define TGT_PORT_BITS     3'h4
`define PWR_NONE          2'h0
`define PWR_CONSUMER      2'h1
`define PWR_MANAGER       2'h2
`define REASON_POWER_ON   4'h0
`define REASON_OPEN       4'h1
`define REASON_HARD_RST   4'h2
`define REASON_SYNC_LOSS  4'h4
`define REASON_BREAK_TO   4'h7
`define REASON_PHY_TEST   4'h8

// ==========================================================
// crc
`define CRC_POLY          32'h04C11DB7
`define CRC_INIT          32'hFFFFFFFF

`endif

// file: common/sas_frame_pkg.sv
// types shared by the address frame builder
// assumes sas_frame_consts.svh for numeric constants
package sas_frame_pkg;

  typedef struct packed {
    logic [63:0] device_name;
    logic [63:0] sas_address;
    logic [7:0]  phy_id;
    logic [1:0]  power_code;
    logic        slumber_ok;
    logic        partial_ok;
  } ident_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } byte_beat_t;

  typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_t;

  typedef enum logic [1:0] {PW_IDLE, PW_PREP, PW_WAIT, PW_USE} pwr_state_t;

endpackage

// file: verilog/sas_identify_frame_builder.sv
// identify address frame builder and address frame receiver
// assumes synchronous byte stream link layer, one clock, sync reset
//
// Notes on behaviour
// - address frames go out and are taken in only outside connections
// - frame is 32 bytes: type in byte 0, bytes 1-27 data, 28-31 crc
// - type 0000b is identify, 0001b open; others reserved, never sent
// - identify frame is sent once the phy reset sequence completes
// - device type bits 6:4 of byte 0 carry end device code 001b
// - byte 1 low nibble carries the link reset reason code
// - all three initiator port bits in byte 2 are zero
// - target port bits in byte 3 are 100b, ssp target only
// - name in bytes 4-11, address 12-19, phy id 20, 23-27 reserved
// - persistent connection capable bit is zero
// - power code 00b silent; 01b issues req and done, acks grants
// - extra power request outstanding on only one phy at a time
// - leave and hold off low power while extra power is in use
// - slumber bit shows support; in slumber only oob is processed
// - partial bit shows support; in partial only oob is processed
// - both zoning bits are zero for an end device
// - break reply capable bit is one; break answered by break reply
// - power disable capable bit, byte 22 bit 0, is one
`include "sas_frame_consts.svh"
`timescale 1ns/1ps

module sas_identify_frame_builder
  import sas_frame_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire ident_cfg_t cfg,
  input  wire logic [3:0] reset_reason,
  input  wire logic       phy_reset_done,
  input  wire logic       connection_open,
  input  wire logic       phy_in_low_power,
  output logic            tx_valid,
  input  wire logic       tx_ready,
  output byte_beat_t      tx_beat,
  input  wire logic       rx_valid,
  input  wire byte_beat_t rx_beat,
  output logic            rx_frame_ok,
  output logic [3:0]      rx_frame_type,
  output logic            rx_crc_err,
  output logic            rx_reserved_type,
  input  wire logic       break_seen,
  output logic            break_reply_send,
  input  wire logic       pwr_want,
  input  wire logic       pwr_finished,
  input  wire logic       pwr_grant_seen,
  input  wire logic       other_phy_pwr_busy,
  output logic            pwr_req_send,
  output logic            pwr_ack_send,
  output logic            pwr_done_send,
  output logic            pwr_pending,
  output logic            low_power_hold,
  output logic            oob_only
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ========================================================
  // crc
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[31] ^ d[i])
        r = {r[30:0], 1'b0} ^ `CRC_POLY;
      else
        r = {r[30:0], 1'b0};
    end
    return r;
  endfunction

  // ========================================================
  // identify frame contents, bytes 0-27
  function automatic logic [27:0][7:0] build_frame(input ident_cfg_t c,
                                                   input logic [3:0] rsn);
    logic [27:0][7:0] f;
    logic [1:0]       pc;
    f = '0;
    // only device side codes are advertised
    pc = (c.power_code == `PWR_CONSUMER) ? `PWR_CONSUMER : `PWR_NONE;
    f[0] = {1'b0, `DEV_END, `TYPE_IDENTIFY};
    f[1] = {4'h0, rsn};
    f[`BYTE_INIT] = {4'h0, `INIT_PORT_BITS, 1'b0};
    f[`BYTE_TGT] = {4'h0, `TGT_PORT_BITS, 1'b0};
    for (int i = 0; i < 8; i++)
    begin
      f[`BYTE_NAME + i] = c.device_name[63 - 8*i -: 8];
      f[`BYTE_ADDR + i] = c.sas_address[63 - 8*i -: 8];
    end
    f[`BYTE_PHY] = c.phy_id;
    // persistent 0, zoning 00, break reply 1
    f[`BYTE_CAPS] = {1'b0, pc, c.slumber_ok, c.partial_ok,
                     2'b00, 1'b1};
    f[`BYTE_PWRDIS] = 8'h01;
    return f;
  endfunction

  // ========================================================
  // transmit
  tx_state_t        tx_state_reg, tx_state_next;
  logic [4:0]       tx_idx_reg, tx_idx_next;
  logic [31:0]      tx_crc_reg, tx_crc_next;
  logic [27:0][7:0] frame_reg, frame_next;
  byte_beat_t       tx_beat_reg, tx_beat_next;
  logic             id_pending_reg, id_pending_next;
  logic [31:0]      crc_step;

  always_comb
  begin
    tx_state_next   = tx_state_reg;
    tx_idx_next     = tx_idx_reg;
    tx_crc_next     = tx_crc_reg;
    frame_next      = frame_reg;
    tx_beat_next    = tx_beat_reg;
    id_pending_next = id_pending_reg | phy_reset_done;
    crc_step        = crc_byte(tx_crc_reg, tx_beat_reg.data);
    case (tx_state_reg)
      TX_IDLE:
      begin
        if (id_pending_next && !connection_open)
        begin
          frame_next      = build_frame(cfg, reset_reason);
          tx_beat_next    = '{data: frame_next[0], last: 1'b0};
          tx_idx_next     = 5'h00;
          tx_crc_next     = `CRC_INIT;
          id_pending_next = 1'b0;
          tx_state_next   = TX_SEND;
        end
      end
      TX_SEND:
      begin
        if (tx_ready)
        begin
          tx_idx_next = tx_idx_reg + 5'h01;
          if (tx_idx_reg < `CRC_FIRST_BYTE)
            tx_crc_next = crc_step;
          if (tx_idx_reg < `CRC_LAST_DATA)
            tx_beat_next.data = frame_reg[tx_idx_next];
          else if (tx_idx_reg == `CRC_LAST_DATA)
            tx_beat_next.data = ~crc_step[31:24];
          else
            tx_beat_next.data = ~tx_crc_reg[8*(30 - tx_idx_reg) +: 8];
          tx_beat_next.last = (tx_idx_next == `FRAME_LAST);
          if (tx_idx_reg == `FRAME_LAST)
          begin
            tx_beat_next  = '0;
            tx_state_next = TX_IDLE;
          end
        end
      end
      default:
        tx_state_next = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_state_reg   <= TX_IDLE;
      tx_idx_reg     <= 5'h00;
      tx_crc_reg     <= `CRC_INIT;
      frame_reg      <= '0;
      tx_beat_reg    <= '0;
      id_pending_reg <= 1'b0;
    end
    else
    begin
      tx_state_reg   <= tx_state_next;
      tx_idx_reg     <= tx_idx_next;
      tx_crc_reg     <= tx_crc_next;
      frame_reg      <= frame_next;
      tx_beat_reg    <= tx_beat_next;
      id_pending_reg <= id_pending_next;
    end
  end

  assign tx_valid = (tx_state_reg == TX_SEND);
  assign tx_beat  = tx_beat_reg;

  // ========================================================
  // receive and classify
  logic [4:0]  rx_idx_reg, rx_idx_next;
  logic [31:0] rx_crc_reg, rx_crc_next;
  logic [23:0] rx_tail_reg, rx_tail_next;
  logic [3:0]  rx_type_reg, rx_type_next;
  logic        rx_ok_reg, rx_ok_next;
  logic        rx_err_reg, rx_err_next;
  logic        rx_rsv_reg, rx_rsv_next;
  logic        rx_take;

  // frames are ignored inside connections and in low power
  assign rx_take = rx_valid && !connection_open && !phy_in_low_power;

  always_comb
  begin
    rx_idx_next  = rx_idx_reg;
    rx_crc_next  = rx_crc_reg;
    rx_tail_next = rx_tail_reg;
    rx_type_next = rx_type_reg;
    rx_ok_next   = 1'b0;
    rx_err_next  = 1'b0;
    rx_rsv_next  = 1'b0;
    if (rx_take)
    begin
      rx_idx_next = rx_idx_reg + 5'h01;
      if (rx_idx_reg == 5'h00)
        rx_crc_next = crc_byte(`CRC_INIT, rx_beat.data);
      else if (rx_idx_reg < `CRC_FIRST_BYTE)
        rx_crc_next = crc_byte(rx_crc_reg, rx_beat.data);
      else
        rx_tail_next = {rx_tail_reg[15:0], rx_beat.data};
      if (rx_idx_reg == 5'h00)
        rx_type_next = rx_beat.data[3:0];
      if (rx_beat.last || rx_idx_reg == `FRAME_LAST)
      begin
        rx_idx_next = 5'h00;
        // short, long or corrupt frames are discarded
        if (rx_beat.last && rx_idx_reg == `FRAME_LAST &&
            {rx_tail_reg, rx_beat.data} == ~rx_crc_reg)
        begin
          rx_ok_next  = 1'b1;
          rx_rsv_next = (rx_type_reg != `TYPE_IDENTIFY) &&
                        (rx_type_reg != `TYPE_OPEN);
        end
        else
          rx_err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_idx_reg  <= 5'h00;
      rx_crc_reg  <= `CRC_INIT;
      rx_tail_reg <= '0;
      rx_type_reg <= 4'h0;
      rx_ok_reg   <= 1'b0;
      rx_err_reg  <= 1'b0;
      rx_rsv_reg  <= 1'b0;
    end
    else
    begin
      rx_idx_reg  <= rx_idx_next;
      rx_crc_reg  <= rx_crc_next;
      rx_tail_reg <= rx_tail_next;
      rx_type_reg <= rx_type_next;
      rx_ok_reg   <= rx_ok_next;
      rx_err_reg  <= rx_err_next;
      rx_rsv_reg  <= rx_rsv_next;
    end
  end

  assign rx_frame_ok      = rx_ok_reg;
  assign rx_frame_type    = rx_type_reg;
  assign rx_crc_err       = rx_err_reg;
  assign rx_reserved_type = rx_rsv_reg;

  // ========================================================
  // break reply, power consumer, low power gating
  pwr_state_t pw_state_reg, pw_state_next;
  logic       brk_reg, brk_next;
  logic       req_reg, req_next;
  logic       ack_reg, ack_next;
  logic       done_reg, done_next;
  logic       consumer;

  assign consumer = (cfg.power_code == `PWR_CONSUMER);

  always_comb
  begin
    pw_state_next = pw_state_reg;
    brk_next      = break_seen;
    req_next      = 1'b0;
    ack_next      = 1'b0;
    done_next     = 1'b0;
    case (pw_state_reg)
      PW_IDLE:
        if (consumer && pwr_want && !other_phy_pwr_busy)
          pw_state_next = PW_PREP;
      PW_PREP:
        // wait for the phy to be active before asking
        if (!consumer)
          pw_state_next = PW_IDLE;
        else if (!phy_in_low_power && !other_phy_pwr_busy)
        begin
          req_next      = 1'b1;
          pw_state_next = PW_WAIT;
        end
      PW_WAIT:
        if (!consumer)
          pw_state_next = PW_IDLE;
        else if (pwr_grant_seen)
        begin
          ack_next      = 1'b1;
          pw_state_next = PW_USE;
        end
      PW_USE:
        if (pwr_finished || !consumer)
        begin
          done_next     = consumer;
          pw_state_next = PW_IDLE;
        end
      default:
        pw_state_next = PW_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pw_state_reg <= PW_IDLE;
      brk_reg      <= 1'b0;
      req_reg      <= 1'b0;
      ack_reg      <= 1'b0;
      done_reg     <= 1'b0;
    end
    else
    begin
      pw_state_reg <= pw_state_next;
      brk_reg      <= brk_next;
      req_reg      <= req_next;
      ack_reg      <= ack_next;
      done_reg     <= done_next;
    end
  end

  assign break_reply_send = brk_reg;
  assign pwr_req_send     = req_reg;
  assign pwr_ack_send     = ack_reg;
  assign pwr_done_send    = done_reg;
  assign pwr_pending      = (pw_state_reg != PW_IDLE);
  assign low_power_hold   = (pw_state_reg != PW_IDLE);
  assign oob_only         = phy_in_low_power;

  // ========================================================
  // checks
  start_idle_a: assert property ($rose(tx_valid) |->
    $past(!connection_open)) else $error("frame started in connection");
  frame_len_a: assert property (tx_valid && tx_beat.last |->
    tx_idx_reg == `FRAME_LAST) else $error("frame length wrong");
  byte0_a: assert property (tx_valid && tx_idx_reg == 5'h00 |->
    tx_beat.data == 8'h10) else $error("byte 0 wrong");
  send_after_a: assert property (phy_reset_done && !tx_valid &&
    !connection_open |=> tx_valid) else $error("identify not sent");
  ports_a: assert property (tx_valid && tx_idx_reg == 5'h02 &&
    tx_ready |=> tx_beat.data == 8'h08) else $error("target bits wrong");
  caps_a: assert property (tx_valid && tx_idx_reg == `BYTE_CAPS |->
    tx_beat.data[7] == 1'b0 && tx_beat.data[2:0] == 3'h1)
    else $error("capability byte wrong");
  pwrdis_a: assert property (tx_valid && tx_idx_reg == `BYTE_PWRDIS |->
    tx_beat.data == 8'h01) else $error("power disable bit wrong");
  break_reply_a: assert property (break_seen |=>
    break_reply_send) else $error("break not answered");
  pwr_silent_a: assert property (!consumer |=>
    !pwr_req_send && !pwr_ack_send) else $error("power code 00 spoke");
  one_phy_a: assert property (pwr_req_send |->
    $past(!other_phy_pwr_busy, 1)) else $error("second phy request");
  lp_hold_a: assert property (pwr_req_send |-> low_power_hold &&
    $past(low_power_hold)) else $error("request without hold");
  crc_discard_a: assert property (rx_crc_err |->
    !rx_frame_ok) else $error("bad frame accepted");

endmodule

// file: tb/link_peer.sv
// far side link model: stalling byte sink and power manager peer
// assumes the builder's byte stream and power pulses, one clock
`timescale 1ns/1ps

module link_peer
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic stall,
  input  wire logic pwr_req_send,
  output logic      tx_ready,
  output logic      pwr_grant_seen
);
  logic [1:0] grant_cnt_reg;
  logic [1:0] grant_cnt_next;

  // ==========================================================
  // grant a request a few cycles after it is seen
  always_comb
  begin
    grant_cnt_next = grant_cnt_reg - {1'b0, grant_cnt_reg != 2'h0};
    if (pwr_req_send)
      grant_cnt_next = 2'h3;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      grant_cnt_reg  <= 2'h0;
      tx_ready       <= 1'b0;
      pwr_grant_seen <= 1'b0;
    end
    else
    begin
      grant_cnt_reg  <= grant_cnt_next;
      tx_ready       <= stall ? 1'($urandom) : 1'b1;
      pwr_grant_seen <= grant_cnt_reg == 2'h1;
    end
  end
endmodule

// file: tb/tb.sv
// testbench for the identify frame builder: tx, rx, break, power
// assumes link_peer as far side, one 25 MHz clock
`timescale 1ns/1ps

module tb
  import sas_frame_pkg::*;
();
  logic       clk, reset, phy_reset_done, connection_open;
  logic       phy_in_low_power, tx_valid, tx_ready, rx_valid;
  logic       rx_frame_ok, rx_crc_err, rx_reserved_type, break_seen;
  logic       break_reply_send, pwr_want, pwr_finished, pwr_grant_seen;
  logic       other_phy_pwr_busy, pwr_req_send, pwr_ack_send;
  logic       pwr_done_send, pwr_pending, low_power_hold, oob_only, stall;
  ident_cfg_t cfg;
  byte_beat_t tx_beat, rx_beat;
  logic [3:0] reset_reason, rx_frame_type;
  logic [7:0] rx_exp, junk [32];
  logic [8:0] txq [$];
  logic [7:0] rxq [$];
  logic [3:0] reasons [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7, 4'h8};
  int         fails, total_checks, n;

  sas_identify_frame_builder uut (.clk(clk), .reset(reset), .cfg(cfg),
    .reset_reason(reset_reason), .phy_reset_done(phy_reset_done),
    .connection_open(connection_open), .phy_in_low_power(phy_in_low_power),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat),
    .rx_valid(rx_valid), .rx_beat(rx_beat), .rx_frame_ok(rx_frame_ok),
    .rx_frame_type(rx_frame_type), .rx_crc_err(rx_crc_err),
    .rx_reserved_type(rx_reserved_type), .break_seen(break_seen),
    .break_reply_send(break_reply_send), .pwr_want(pwr_want),
    .pwr_finished(pwr_finished), .pwr_grant_seen(pwr_grant_seen),
    .other_phy_pwr_busy(other_phy_pwr_busy), .pwr_req_send(pwr_req_send),
    .pwr_ack_send(pwr_ack_send), .pwr_done_send(pwr_done_send),
    .pwr_pending(pwr_pending), .low_power_hold(low_power_hold),
    .oob_only(oob_only));

  link_peer peer (.clk(clk), .reset(reset), .stall(stall),
    .pwr_req_send(pwr_req_send), .tx_ready(tx_ready),
    .pwr_grant_seen(pwr_grant_seen));

  always #20 clk = ~clk;

  // ==========================================================
  // helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task results();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] crc_of(input logic [7:0] b [32]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 28; i++)
      for (int k = 7; k >= 0; k--)
        c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i][k]) ? 32'h04C11DB7 : 32'h0);
    return ~c;
  endfunction

  task ident(input logic [3:0] r);
    logic [7:0] b [32];
    logic [1:0] pc;
    pc = (cfg.power_code == 2'h1) ? 2'h1 : 2'h0;
    b[0] = 8'h10;
    b[1] = {4'h0, r};
    b[2] = 8'h00;
    b[3] = 8'h08;
    for (int i = 0; i < 8; i++)
    begin
      b[4 + i] = cfg.device_name[63 - 8 * i -: 8];
      b[12 + i] = cfg.sas_address[63 - 8 * i -: 8];
    end
    b[20] = cfg.phy_id;
    b[21] = {1'b0, pc, cfg.slumber_ok, cfg.partial_ok, 3'h1};
    b[22] = 8'h01;
    for (int i = 23; i < 28; i++)
      b[i] = 8'h00;
    {b[28], b[29], b[30], b[31]} = crc_of(b);
    for (int i = 0; i < 32; i++)
      txq.push_back({i == 31, b[i]});
    reset_reason <= r;
    phy_reset_done <= 1'b1;
    @(posedge clk) phy_reset_done <= 1'b0;
  endtask

  task drain();
    for (n = 0; n < 400 && txq.size() != 0; n++)
      @(posedge clk);
    check(txq.size(), 0);
    @(posedge clk);
  endtask

  task put_rx(input logic [7:0] b [32], input int cnt);
    for (int i = 0; i < cnt; i++)
    begin
      rx_valid <= 1'b1;
      rx_beat <= '{data: b[i], last: i == 31};
      @(posedge clk);
    end
    rx_valid <= 1'b0;
  endtask

  task rx_frame(input logic [3:0] t, input logic bad);
    logic [7:0] b [32];
    for (int i = 1; i < 28; i++)
      b[i] = 8'($urandom);
    b[0] = {4'h0, t};
    {b[28], b[29], b[30], b[31]} = crc_of(b);
    if (bad)
      b[30] = ~b[30];
    rxq.push_back({~bad, bad, ~bad && t > 4'h1, 1'b0, t});
    put_rx(b, 32);
  endtask

  // ==========================================================
  // output monitor
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      check({tx_beat.last, tx_beat.data},
            txq.size() ? txq.pop_front() : 9'h1FF);
    if (rx_frame_ok === 1'b1 || rx_crc_err === 1'b1)
    begin
      rx_exp = rxq.size() ? rxq.pop_front() : 8'hFF;
      check({rx_frame_ok, rx_crc_err, rx_reserved_type}, rx_exp[7:5]);
      if (rx_exp[7])
        check(rx_frame_type, rx_exp[3:0]);
    end
  end

  initial
  begin
    #400000;
    fails++;
    results();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    clk = 0; reset = 1; cfg = '0; reset_reason = 0; phy_reset_done = 0;
    connection_open = 0; phy_in_low_power = 0; rx_valid = 0; rx_beat = '0;
    break_seen = 0; pwr_want = 0; pwr_finished = 0; stall = 0;
    other_phy_pwr_busy = 0;
    void'($urandom(57096));
    foreach (junk[i])
      junk[i] = 8'($urandom);
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      cfg <= '{device_name: {$urandom, $urandom}, phy_id: 8'($urandom),
               sas_address: {$urandom, $urandom}, power_code: 2'($urandom),
               slumber_ok: 1'($urandom), partial_ok: 1'($urandom)};
      stall <= i > 1;
      @(posedge clk);
      ident(reasons[i]);
      if (i % 2)
        drain();
    end
    connection_open <= 1'b1;
    @(posedge clk);
    ident(4'h2);
    repeat (8) @(posedge clk);
    check(tx_valid, 0);
    connection_open <= 1'b0;
    drain();
    rx_frame(4'h0, 0);
    rx_frame(4'h1, 0);
    rx_frame(4'h5, 0);
    rx_frame(4'h0, 1);
    connection_open <= 1'b1;
    put_rx(junk, 10);
    connection_open <= 1'b0;
    rx_frame(4'h1, 0);
    repeat (3) @(posedge clk);
    check(rxq.size(), 0);
    break_seen <= 1'b1;
    @(posedge clk) break_seen <= 1'b0;
    #1 check(break_reply_send, 1);
    @(posedge clk) cfg.power_code <= 2'h0;
    pwr_want <= 1'b1;
    @(posedge clk) pwr_want <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check({pwr_pending, pwr_req_send}, 0);
    @(posedge clk) cfg.power_code <= 2'h1;
    other_phy_pwr_busy <= 1'b1;
    pwr_want <= 1'b1;
    repeat (5) @(posedge clk);
    #1 check({pwr_pending, pwr_req_send}, 0);
    @(posedge clk) pwr_want <= 1'b0;
    other_phy_pwr_busy <= 1'b0;
    phy_in_low_power <= 1'b1;
    @(posedge clk) pwr_want <= 1'b1;
    @(posedge clk) pwr_want <= 1'b0;
    @(posedge clk) #1 check({pwr_pending, low_power_hold, oob_only}, 7);
    for (int i = 0; i < 4; i++)
      @(posedge clk) #1 check(pwr_req_send, 0);
    @(posedge clk) phy_in_low_power <= 1'b0;
    for (n = 0; n < 10 && pwr_req_send !== 1'b1; n++)
      @(posedge clk) #1;
    check({n < 10, oob_only}, 2);
    for (n = 0; n < 10 && pwr_ack_send !== 1'b1; n++)
      @(posedge clk) #1;
    check({n < 10, low_power_hold}, 3);
    @(posedge clk) pwr_finished <= 1'b1;
    @(posedge clk) pwr_finished <= 1'b0;
    #1 check(pwr_done_send, 1);
    @(posedge clk) #1 check({pwr_pending, low_power_hold}, 0);
    results();
  end
endmodule
